// ==== core/servo_position_output_control.v ====
// Position-proportional servo output stage with Avalon-MM register slave
//
// Contract
// - Reverse default; direct mirrors output
// - Direction change refused during auto tuning
// - Feedback reset output: stop or preset
// - No feedback: reset/error action, Close default
// - Reset output held despite input error
// - Scale-over applies input error output
// - Reset output outranks input error output
// - Pot fault output stop/close/open, Stop default
// - Pot fault outranks reset and error
// - Rate limiter 0.1-100.0 %/s, default off
// - Selection inputs only; all off means PID
// - Width one, three or seven presets
// - Wider widths claim select inputs 1, 2
// - Feedback presets 0-100 %, default 0
// - No feedback: fixed preset actions
// - Feedback enable chooses pot or timing
// - Feedback enable written only in standby
// - Dead band 0.2-10.0 %, default 2.0
// - Timed position estimate, stroke 5-300 s
// - Boot Stop assumes 50 % position
// - Boot Close/Open drives one stroke first
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "servo_output_regs.vh"
`default_nettype none

module servo_position_output_control #(
   parameter MS_TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
   // Clock, reset, enable
   input wire clk_sys_i,
   input wire rst_i,
   input wire clk_en_i,
   // Avalon-MM slave
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // Controller state
   input wire run_i,
   input wire standby_state_i,
   input wire auto_tuning_i,
   input wire input_error_i,
   input wire pot_fault_i,
   input wire [9:0] pid_output_i,
   input wire [9:0] feedback_position_i,
   // Preset selection inputs
   input wire select_input_0_i,
   input wire select_input_1_i,
   input wire select_input_2_i,
   output wire [2:0] select_claimed_o,
   // Motor drive and observation
   output reg drive_open_o,
   output reg drive_close_o,
   output reg [9:0] output_value_o,
   output reg [9:0] position_o
);

   localparam S_START = 2'h0;
   localparam S_BOOT = 2'h1;
   localparam S_CTRL = 2'h2;

   // Configuration registers
   reg direct_q;
   reg feedback_enable_q;
   reg [1:0] width_q;
   reg [1:0] boot_q;
   reg [3:0] fb_rst_q;
   reg [3:0] fb_err_q;
   reg [1:0] nofb_rst_q;
   reg [1:0] nofb_err_q;
   reg [1:0] pot_fault_output_q;
   reg [9:0] rate_q;
   reg [6:0] dead_band_width_q;
   reg [8:0] stroke_q;
   reg [9:0] position_slot_q [1:7];

   // Bus slave state
   reg ack_q;
   reg [31:0] rdata_q;

   // Runtime state
   reg [1:0] state_q;
   reg [17:0] ms_cnt_q;
   reg ms_tick_q;
   reg [10:0] rate_acc_q;
   reg [9:0] limited_q;
   reg [8:0] est_acc_q;
   reg [9:0] est_q;
   reg [18:0] boot_cnt_q;
   reg fb_was_q;

   // Combinational demand
   reg [2:0] sel_idx;
   reg use_action;
   reg [1:0] action;
   reg [9:0] target;
   reg [10:0] diff_abs;
   reg diff_pos;
   reg [31:0] rd_mux;
   reg [31:0] wmask;
   wire [9:0] pid_dir;
   wire [18:0] stroke_ms;
   wire req;
   wire wr_go;
   wire [31:0] wval_ctl;
   wire [31:0] wval_fbk;
   wire [31:0] wval_rate;
   wire [31:0] wval_db;
   wire [31:0] wval_str;
   integer i;

   // One wait cycle per access; read data is captured on the waiting edge, write data lands on the released edge
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_q;
   assign avs_readdata_o = rdata_q;
   assign wr_go = avs_write_i & ack_q;

   // Byte-lane mask from the enables
   always @* begin
      wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   end

   // Merged register images, so partial writes keep untouched lanes; preset slot writes merge with the rate image
   assign wval_ctl = (avs_writedata_i & wmask) | ({26'h0, boot_q, width_q,
                     feedback_enable_q, direct_q} & ~wmask);
   assign wval_fbk = (avs_writedata_i & wmask) | ({18'h0, pot_fault_output_q,
                     nofb_err_q, nofb_rst_q, fb_err_q, fb_rst_q} & ~wmask);
   assign wval_rate = (avs_writedata_i & wmask) | ({22'h0, rate_q} & ~wmask);
   assign wval_db = (avs_writedata_i & wmask) | ({25'h0, dead_band_width_q} & ~wmask);
   assign wval_str = (avs_writedata_i & wmask) | ({23'h0, stroke_q} & ~wmask);

   // Preset inputs claimed by the chosen switching width
   assign select_claimed_o = (width_q == `WIDTH_THREE) ? 3'h7 :
                             (width_q == `WIDTH_TWO) ? 3'h3 :
                             (width_q == `WIDTH_ONE) ? 3'h1 : 3'h0;

   // Demand computed for reverse; direct action mirrors it
   assign pid_dir = direct_q ? (`POS_FULL - pid_output_i) : pid_output_i;
   assign stroke_ms = stroke_q * 10'h3E8;

   // Read mux
   always @* begin
      rd_mux = 32'h0;
      case (avs_address_i)
         `REG_CONTROL: rd_mux = {26'h0, boot_q, width_q, feedback_enable_q, direct_q};
         `REG_FALLBACK: rd_mux = {18'h0, pot_fault_output_q, nofb_err_q, nofb_rst_q,
                                  fb_err_q, fb_rst_q};
         `REG_RATE: rd_mux = {22'h0, rate_q};
         `REG_DEAD_BAND: rd_mux = {25'h0, dead_band_width_q};
         `REG_STROKE: rd_mux = {23'h0, stroke_q};
         `REG_STATUS: rd_mux = {8'h0, state_q, drive_close_o, drive_open_o,
                                output_value_o, position_o};
         default: begin
            if (avs_address_i >= `REG_POS_SLOT_FIRST && avs_address_i <= `REG_POS_SLOT_LAST)
               rd_mux = {22'h0, position_slot_q[avs_address_i - 4'h4]};
         end
      endcase
   end

   // Bus handshake and configuration writes
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
         direct_q <= `RST_DIRECT;
         feedback_enable_q <= `RST_FEEDBACK;
         width_q <= `RST_WIDTH;
         boot_q <= `RST_BOOT;
         fb_rst_q <= `RST_FB_RST;
         fb_err_q <= `RST_FB_ERR;
         nofb_rst_q <= `RST_NOFB_RST;
         nofb_err_q <= `RST_NOFB_ERR;
         pot_fault_output_q <= `RST_POT_FAULT;
         rate_q <= `RST_RATE;
         dead_band_width_q <= `RST_DEAD_BAND;
         stroke_q <= `RST_STROKE;
         for (i = 1; i <= 7; i = i + 1)
            position_slot_q[i] <= `RST_POS_SLOT;
      end else if (clk_en_i) begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
            rdata_q <= rd_mux;
         if (wr_go) begin
            case (avs_address_i)
               `REG_CONTROL: begin
                  // Direction locked while tuning runs
                  if (!auto_tuning_i)
                     direct_q <= wval_ctl[`CTL_DIRECT_BIT];
                  // Source of position only switched from standby
                  if (standby_state_i)
                     feedback_enable_q <= wval_ctl[`CTL_FEEDBACK_BIT];
                  width_q <= wval_ctl[`CTL_WIDTH_LSB +: 2];
                  if (wval_ctl[`CTL_BOOT_LSB +: 2] != 2'h3)
                     boot_q <= wval_ctl[`CTL_BOOT_LSB +: 2];
               end
               `REG_FALLBACK: begin
                  // Out-of-range codes are ignored, field keeps its value
                  if (wval_fbk[`FB_RST_LSB +: 4] <= 4'h7)
                     fb_rst_q <= wval_fbk[`FB_RST_LSB +: 4];
                  if (wval_fbk[`FB_ERR_LSB +: 4] <= 4'h7)
                     fb_err_q <= wval_fbk[`FB_ERR_LSB +: 4];
                  if (wval_fbk[`NOFB_RST_LSB +: 2] != 2'h3)
                     nofb_rst_q <= wval_fbk[`NOFB_RST_LSB +: 2];
                  if (wval_fbk[`NOFB_ERR_LSB +: 2] != 2'h3)
                     nofb_err_q <= wval_fbk[`NOFB_ERR_LSB +: 2];
                  if (wval_fbk[`POT_FAULT_LSB +: 2] != 2'h3)
                     pot_fault_output_q <= wval_fbk[`POT_FAULT_LSB +: 2];
               end
               `REG_RATE: begin
                  // Zero switches the limiter off; above range saturates
                  if (wval_rate[9:0] > `RATE_MAX || wval_rate[31:10] != 22'h0)
                     rate_q <= `RATE_MAX;
                  else
                     rate_q <= wval_rate[9:0];
               end
               `REG_DEAD_BAND: begin
                  if (wval_db[31:7] != 25'h0 || wval_db[6:0] > `DB_MAX)
                     dead_band_width_q <= `DB_MAX;
                  else if (wval_db[6:0] < `DB_MIN)
                     dead_band_width_q <= `DB_MIN;
                  else
                     dead_band_width_q <= wval_db[6:0];
               end
               `REG_STROKE: begin
                  if (wval_str[31:9] != 23'h0 || wval_str[8:0] > `STROKE_MAX)
                     stroke_q <= `STROKE_MAX;
                  else if (wval_str[8:0] < `STROKE_MIN)
                     stroke_q <= `STROKE_MIN;
                  else
                     stroke_q <= wval_str[8:0];
               end
               default: begin
                  if (avs_address_i >= `REG_POS_SLOT_FIRST &&
                      avs_address_i <= `REG_POS_SLOT_LAST) begin
                     if (wval_rate[9:0] > `POS_FULL || wval_rate[31:10] != 22'h0)
                        position_slot_q[avs_address_i - 4'h4] <= `POS_FULL;
                     else
                        position_slot_q[avs_address_i - 4'h4] <= wval_rate[9:0];
                  end
               end
            endcase
         end
      end
   end

   // Preset index from the claimed inputs, input 0 as the low bit
   always @* begin
      case (width_q)
         `WIDTH_ONE: sel_idx = {2'b00, select_input_0_i};
         `WIDTH_TWO: sel_idx = {1'b0, select_input_1_i, select_input_0_i};
         `WIDTH_THREE: sel_idx = {select_input_2_i, select_input_1_i, select_input_0_i};
         default: sel_idx = 3'h0;
      endcase
   end

   // Demand selection: pot fault, then reset, then input error, then preset, then PID
   always @* begin
      use_action = 1'b0;
      action = `ACT_STOP;
      target = limited_q;
      if (feedback_enable_q && pot_fault_i) begin
         use_action = 1'b1;
         action = pot_fault_output_q;
      end else if (!run_i) begin
         // Reset wins regardless of any input error
         if (feedback_enable_q) begin
            use_action = (fb_rst_q == 4'h0);
            target = (fb_rst_q == 4'h0) ? limited_q : position_slot_q[fb_rst_q[2:0]];
         end else begin
            use_action = 1'b1;
            action = nofb_rst_q;
         end
      end else if (input_error_i) begin
         if (feedback_enable_q) begin
            use_action = (fb_err_q == 4'h0);
            target = (fb_err_q == 4'h0) ? limited_q : position_slot_q[fb_err_q[2:0]];
         end else begin
            use_action = 1'b1;
            action = nofb_err_q;
         end
      end else if (sel_idx != 3'h0) begin
         if (feedback_enable_q) begin
            target = position_slot_q[sel_idx];
         end else begin
            use_action = 1'b1;
            action = (sel_idx == 3'h2) ? `ACT_CLOSE :
                     (sel_idx == 3'h3) ? `ACT_OPEN : `ACT_STOP;
         end
      end
   end

   // Signed gap between target and position
   always @* begin
      diff_pos = (target > position_o);
      diff_abs = diff_pos ? ({1'b0, target} - {1'b0, position_o}) :
                 ({1'b0, position_o} - {1'b0, target});
   end

   // Millisecond time base, counts are long so the divider is a parameter
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ms_cnt_q <= 18'h0;
         ms_tick_q <= 1'b0;
      end else if (clk_en_i) begin
         ms_tick_q <= (ms_cnt_q == MS_TICK_CYCLES - 1);
         if (ms_cnt_q == MS_TICK_CYCLES - 1)
            ms_cnt_q <= 18'h0;
         else
            ms_cnt_q <= ms_cnt_q + 18'h1;
      end
   end

   // Rate limiter: rate per second accumulated per ms, at most one 0.1 % step per ms
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rate_acc_q <= 11'h0;
         limited_q <= 10'h0;
      end else if (clk_en_i) begin
         if (rate_q == 10'h0) begin
            rate_acc_q <= 11'h0;
            limited_q <= pid_dir;
         end else if (ms_tick_q) begin
            if (rate_acc_q + {1'b0, rate_q} >= `POS_SCALE) begin
               rate_acc_q <= rate_acc_q + {1'b0, rate_q} - `POS_SCALE;
               if (limited_q < pid_dir)
                  limited_q <= limited_q + 10'h1;
               else if (limited_q > pid_dir)
                  limited_q <= limited_q - 10'h1;
            end else begin
               rate_acc_q <= rate_acc_q + {1'b0, rate_q};
            end
         end
      end
   end

   // Start-up positioning, timed estimate and drive outputs
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_START;
         est_acc_q <= 9'h0;
         est_q <= `POS_HALF;
         fb_was_q <= 1'h1;
         boot_cnt_q <= 19'h0;
         drive_open_o <= 1'b0;
         drive_close_o <= 1'b0;
         output_value_o <= 10'h0;
         position_o <= 10'h0;
      end else if (clk_en_i) begin
         output_value_o <= limited_q;
         fb_was_q <= feedback_enable_q;
         // Position source chosen by the feedback setting
         position_o <= feedback_enable_q ? feedback_position_i : est_q;
         case (state_q)
            S_START: begin
               boot_cnt_q <= 19'h0;
               est_acc_q <= 9'h0;
               if (feedback_enable_q || boot_q == `ACT_STOP) begin
                  est_q <= `POS_HALF;
                  state_q <= S_CTRL;
               end else begin
                  state_q <= S_BOOT;
               end
            end
            S_BOOT: begin
               // Drive one full stroke against the limit switch
               drive_open_o <= (boot_q == `ACT_OPEN);
               drive_close_o <= (boot_q == `ACT_CLOSE);
               if (ms_tick_q)
                  boot_cnt_q <= boot_cnt_q + 19'h1;
               if (ms_tick_q && boot_cnt_q + 19'h1 >= stroke_ms) begin
                  est_q <= (boot_q == `ACT_OPEN) ? `POS_FULL : 10'h0;
                  drive_open_o <= 1'b0;
                  drive_close_o <= 1'b0;
                  state_q <= S_CTRL;
               end
            end
            S_CTRL: begin
               if (fb_was_q && !feedback_enable_q)
                  state_q <= S_START;
               if (use_action) begin
                  drive_open_o <= (action == `ACT_OPEN);
                  drive_close_o <= (action == `ACT_CLOSE);
               end else begin
                  // Half the band on each side, so small errors cannot hunt
                  drive_open_o <= diff_pos && ({diff_abs, 1'b0} > {5'h0, dead_band_width_q});
                  drive_close_o <= !diff_pos && ({diff_abs, 1'b0} > {5'h0, dead_band_width_q});
               end
               // Estimate moves one 0.1 % step per stroke-seconds of drive in ms
               if (ms_tick_q && (drive_open_o || drive_close_o)) begin
                  if (est_acc_q + 9'h1 >= stroke_q) begin
                     est_acc_q <= 9'h0;
                     if (drive_open_o && est_q < `POS_FULL)
                        est_q <= est_q + 10'h1;
                     else if (drive_close_o && est_q != 10'h0)
                        est_q <= est_q - 10'h1;
                  end else begin
                     est_acc_q <= est_acc_q + 9'h1;
                  end
               end
            end
            default: state_q <= S_START;
         endcase
      end
   end

endmodule // servo_position_output_control
`default_nettype wire

// ==== core/servo_output_regs.vh ====
// Register map, field layout, reset values and timing counts of the servo output stage
`ifndef SERVO_OUTPUT_REGS_VH
`define SERVO_OUTPUT_REGS_VH

// Word offsets (byte address = 4 * index)
`define REG_CONTROL 4'h0
`define REG_FALLBACK 4'h1
`define REG_RATE 4'h2
`define REG_DEAD_BAND 4'h3
`define REG_STROKE 4'h4
`define REG_POS_SLOT_FIRST 4'h5
`define REG_POS_SLOT_LAST 4'hB
`define REG_STATUS 4'hC

// Control register fields
`define CTL_DIRECT_BIT 0
`define CTL_FEEDBACK_BIT 1
`define CTL_WIDTH_LSB 2
`define CTL_BOOT_LSB 4

// Fallback register fields
`define FB_RST_LSB 0
`define FB_ERR_LSB 4
`define NOFB_RST_LSB 8
`define NOFB_ERR_LSB 10
`define POT_FAULT_LSB 12

// Action codes
`define ACT_STOP 2'h0
`define ACT_CLOSE 2'h1
`define ACT_OPEN 2'h2

// Preset switching widths
`define WIDTH_NONE 2'h0
`define WIDTH_ONE 2'h1
`define WIDTH_TWO 2'h2
`define WIDTH_THREE 2'h3

// Reset values
`define RST_DIRECT 1'h0
`define RST_FEEDBACK 1'h1
`define RST_WIDTH 2'h0
`define RST_BOOT 2'h1
`define RST_FB_RST 4'h1
`define RST_FB_ERR 4'h0
`define RST_NOFB_RST 2'h1
`define RST_NOFB_ERR 2'h1
`define RST_POT_FAULT 2'h0
`define RST_RATE 10'h000
`define RST_DEAD_BAND 7'h14
`define RST_STROKE 9'h03C
`define RST_POS_SLOT 10'h000

// Ranges, 0.1 % and 0.1 %/s units, seconds
`define RATE_MAX 10'h3E8
`define DB_MIN 7'h02
`define DB_MAX 7'h64
`define STROKE_MIN 9'h005
`define STROKE_MAX 9'h12C
`define POS_FULL 10'h3E8
`define POS_HALF 10'h1F4
`define POS_SCALE 11'h3E8

// Timing
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000000
`define MS_PER_S 1000

`endif

// ==== testbench/servo_position_output_control_assertions.sv ====
// Port-level concurrent checks for the servo output stage
`default_nettype none

module servo_output_checker (
   // Clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // Register bus
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   // Motor side
   input wire [2:0] select_claimed_o,
   input wire drive_open_o,
   input wire drive_close_o,
   input wire [9:0] output_value_o,
   input wire [9:0] position_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // One clock domain
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   // Fresh request, one wait cycle, then the answer
   sequence s_start;
      $rose(avs_read_i || avs_write_i);
   endsequence
   sequence s_one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   property p_one_wait;
      s_start |-> s_one_wait;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus access not answered after one wait cycle");

   // Unmapped words read back as zero
   property p_unmapped_zero;
      avs_read_i && !avs_waitrequest_o && avs_address_i > 4'hC |-> avs_readdata_o == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read returned nonzero data");

   // Open and close never together
   property p_no_both;
      !(drive_open_o && drive_close_o);
   endproperty
   a_no_both: assert property (p_no_both)
      else $error("open and close driven together");

   // Claimed inputs grow from selector 0 upward
   property p_claim_shape;
      select_claimed_o inside {3'h0, 3'h1, 3'h3, 3'h7};
   endproperty
   a_claim_shape: assert property (p_claim_shape)
      else $error("claimed selector pattern not contiguous");

   // Claims move only after a control write
   property p_claim_cause;
      $changed(select_claimed_o) |->
         $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0);
   endproperty
   a_claim_cause: assert property (p_claim_cause)
      else $error("selector claim changed without a control write");

   // Demand stays inside the full scale
   property p_out_range;
      output_value_o <= 10'h3E8;
   endproperty
   a_out_range: assert property (p_out_range)
      else $error("output value above full scale");

   // Estimate is clamped at the stroke ends
   property p_pos_range;
      position_o <= 10'h3E8;
   endproperty
   a_pos_range: assert property (p_pos_range)
      else $error("position above full scale");

   // Nothing is driven at the first edge after reset
   property p_reset_quiet;
      $fell(rst_i) |-> !drive_open_o && !drive_close_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("motor driven at reset release");
endmodule // servo_output_checker

bind servo_position_output_control servo_output_checker chk_u (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .select_claimed_o(select_claimed_o),
   .drive_open_o(drive_open_o),
   .drive_close_o(drive_close_o),
   .output_value_o(output_value_o),
   .position_o(position_o)
);
`default_nettype wire

// ==== testbench/motor_model.sv ====
// Slow limit-switched control motor with a potentiometer pickup
`default_nettype none

module motor_model #(
   parameter int STEP_CYC = 1000
) (
   // Clock
   input wire logic clk_i,
   // Drives and a bench preload of the shaft
   input wire logic open_i,
   input wire logic close_i,
   input wire logic load_i,
   input wire logic [9:0] load_val_i,
   // Potentiometer reading
   output logic [9:0] pos_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;

   // Limit switches stop travel at the ends
   initial pos_o = 10'h1F4;
   always @(posedge clk_i) begin
      cnt <= ((open_i || close_i) && cnt < STEP_CYC) ? cnt + 1 : 0;
      if (load_i) pos_o <= load_val_i;
      else if (cnt == STEP_CYC && open_i && pos_o < 10'h3E8) pos_o <= pos_o + 10'h001;
      else if (cnt == STEP_CYC && close_i && pos_o > 10'h000) pos_o <= pos_o - 10'h001;
   end
endmodule // motor_model
`default_nettype wire

// ==== testbench/servo_position_output_control_tb.sv ====
// Self-checking bench for the servo output stage
`default_nettype none

module servo_position_output_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Flags: feedback, direct, run, input error, pot fault
   typedef struct packed {logic [4:0] f; logic [1:0] wid; logic [2:0] sel; logic [9:0] pid;
      logic [1:0] dr;} row_t;
   typedef struct packed {logic we; logic [3:0] a; logic [11:0] d; logic [11:0] e;} reg_row_t;
   localparam logic [9:0] P = 10'h1F4;
   logic clk_sys_i = 1'h0, rst_i = 1'h1, clk_en_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
   logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
   logic [31:0] avs_writedata_i = 32'h0, rdat;
   logic run_i = 1'h0, standby_state_i = 1'h1, auto_tuning_i = 1'h0, load_i = 1'h0;
   logic input_error_i = 1'h0, pot_fault_i = 1'h0;
   logic select_input_0_i = 1'h0, select_input_1_i = 1'h0, select_input_2_i = 1'h0;
   logic [9:0] pid_output_i = P, p0;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, drive_open_o, drive_close_o;
   wire [2:0] select_claimed_o;
   wire [9:0] output_value_o, position_o, feedback_position_i;
   wire [1:0] dr = {drive_open_o, drive_close_o};
   int error_cnt = 0, samples_checked = 0;
   // Reset values, then clamping of range fields
   reg_row_t regs [15] = '{'{1'h0, 4'h0, 12'h000, 12'h012}, '{1'h0, 4'h1, 12'h000, 12'h501},
      '{1'h0, 4'h2, 12'h000, 12'h000}, '{1'h0, 4'h3, 12'h000, 12'h014},
      '{1'h0, 4'h4, 12'h000, 12'h03C}, '{1'h0, 4'hB, 12'h000, 12'h000},
      '{1'h1, 4'hD, 12'h005, 12'h000}, '{1'h1, 4'h2, 12'h7D0, 12'h3E8},
      '{1'h1, 4'h3, 12'h001, 12'h002}, '{1'h1, 4'h3, 12'h0C8, 12'h064},
      '{1'h1, 4'h3, 12'h014, 12'h014}, '{1'h1, 4'h4, 12'h190, 12'h12C},
      '{1'h1, 4'h4, 12'h005, 12'h005}, '{1'h1, 4'h5, 12'h7D0, 12'h3E8},
      '{1'h1, 4'h2, 12'h000, 12'h000}};
   // Direction and dead band, fallbacks, presets with and without feedback
   row_t rows [25] = '{'{5'h14, 2'h0, 3'h0, 10'h258, 2'h2}, '{5'h14, 2'h0, 3'h0, 10'h1FF, 2'h2},
      '{5'h14, 2'h0, 3'h0, 10'h1FE, 2'h0}, '{5'h14, 2'h0, 3'h0, 10'h1E9, 2'h1},
      '{5'h1C, 2'h0, 3'h0, 10'h258, 2'h1}, '{5'h1C, 2'h0, 3'h0, 10'h1E9, 2'h2},
      '{5'h10, 2'h0, 3'h0, P, 2'h1}, '{5'h12, 2'h0, 3'h0, P, 2'h1}, '{5'h16, 2'h0, 3'h0, P, 2'h2},
      '{5'h13, 2'h0, 3'h0, P, 2'h2}, '{5'h15, 2'h0, 3'h0, P, 2'h2}, '{5'h14, 2'h3, 3'h5, P, 2'h2},
      '{5'h14, 2'h3, 3'h6, P, 2'h1}, '{5'h14, 2'h3, 3'h0, P, 2'h0}, '{5'h14, 2'h1, 3'h2, P, 2'h0},
      '{5'h14, 2'h1, 3'h1, P, 2'h2}, '{5'h14, 2'h2, 3'h7, P, 2'h2}, '{5'h14, 2'h2, 3'h2, P, 2'h1},
      '{5'h04, 2'h3, 3'h2, P, 2'h1}, '{5'h04, 2'h3, 3'h3, P, 2'h2}, '{5'h04, 2'h3, 3'h1, P, 2'h0},
      '{5'h04, 2'h3, 3'h4, P, 2'h0}, '{5'h00, 2'h0, 3'h0, P, 2'h1}, '{5'h06, 2'h0, 3'h0, P, 2'h2},
      '{5'h02, 2'h0, 3'h0, P, 2'h1}};

   // Short tick keeps boot and timing runs brief
   servo_position_output_control #(.MS_TICK_CYCLES(2)) dut_u (.*);
   motor_model mot_u (.clk_i(clk_sys_i), .open_i(drive_open_o), .close_i(drive_close_o),
      .load_i(load_i), .load_val_i(P), .pos_o(feedback_position_i));

   // 250 MHz clock
   initial forever #2 clk_sys_i = ~clk_sys_i;

   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= we;
      avs_read_i <= !we;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'h0);
      rd = avs_readdata_o;
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
   endtask

   // Let drives follow, then sample away from the edge
   task automatic settle();
      @(posedge clk_sys_i);
      load_i <= 1'h0;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask

   // Hang guard, well beyond boot plus all cases
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      error_cnt++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      foreach (regs[i]) begin
         if (regs[i].we) bus(1'h1, regs[i].a, {20'h0, regs[i].d}, rdat);
         bus(1'h0, regs[i].a, 32'h0, rdat);
         chk(rdat, {20'h0, regs[i].e});
      end
      do bus(1'h0, 4'hC, 32'h0, rdat); while (rdat[23:22] !== 2'h2);
      // Fallbacks: reset preset 2, error preset 3, no-feedback error and pot fault open
      bus(1'h1, 4'h1, 32'h2932, rdat);
      for (int i = 0; i < 7; i++) bus(1'h1, 4'h5 + i[3:0], i[0] ? 32'h64 : 32'h384, rdat);
      foreach (rows[i]) begin
         bus(1'h1, 4'h0, {26'h0, 2'h0, rows[i].wid, rows[i].f[4:3]}, rdat);
         {run_i, input_error_i, pot_fault_i} <= rows[i].f[2:0];
         {select_input_2_i, select_input_1_i, select_input_0_i} <= rows[i].sel;
         pid_output_i <= rows[i].pid;
         load_i <= 1'h1;
         settle();
         chk(dr, rows[i].dr);
         chk(select_claimed_o, 3'h7 >> (2'h3 - rows[i].wid));
      end
      // Timed estimate climbs one step per stroke count of ticks while opening
      @(posedge clk_sys_i);
      {run_i, input_error_i} <= 2'h2;
      pid_output_i <= 10'h3E8;
      settle();
      p0 = position_o;
      repeat (100) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk((position_o - p0) inside {[10'h009:10'h00B]}, 1'h1);
      // Rate limit at full setting: one step per tick
      @(posedge clk_sys_i);
      pid_output_i <= 10'h000;
      settle();
      bus(1'h1, 4'h2, 32'h3E8, rdat);
      pid_output_i <= 10'h064;
      repeat (40) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(output_value_o inside {[10'h011:10'h017]}, 1'h1);
      bus(1'h1, 4'h2, 32'h0, rdat);
      // Direction frozen during tuning, feedback frozen outside standby
      auto_tuning_i <= 1'h1;
      bus(1'h1, 4'h0, 32'h13, rdat);
      bus(1'h0, 4'h0, 32'h0, rdat);
      chk(rdat[1:0], 2'h2);
      auto_tuning_i <= 1'h0;
      standby_state_i <= 1'h0;
      bus(1'h1, 4'h0, 32'h10, rdat);
      bus(1'h0, 4'h0, 32'h0, rdat);
      chk(rdat[1:0], 2'h2);
      // Pot off reruns close start-up
      standby_state_i <= 1'h1;
      bus(1'h1, 4'h0, 32'h10, rdat);
      settle();
      chk(dr, 2'h1);
      do bus(1'h0, 4'hC, 32'h0, rdat); while (rdat[23:22] !== 2'h2);
      chk(position_o, 10'h000);
      // Second reset restores defaults
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      bus(1'h0, 4'h0, 32'h0, rdat);
      chk(rdat, 32'h12);
      close_out();
   end
endmodule // servo_position_output_control_tb
`default_nettype wire
